/* core/svr_params.svh */
// Constants for the stop recovery and voltage detect block.
`ifndef SVR_PARAMS_SVH
`define SVR_PARAMS_SVH
// ----------------------------------------
// Register map and fields
// ----------------------------------------
`define SVR_BANK_F        4'hf
`define SVR_ADDR_RECOVERY 8'h0b
`define SVR_ADDR_VDETECT  8'h0c
`define SVR_ADDR_IRQSTAT  8'h0d
`define SVR_ADDR_IRQMASK  8'h0e
`define SVR_ADDR_STOPCMD  8'h0f
`define SVR_BIT_WARM      7
`define SVR_BIT_LEVEL     6
`define SVR_BIT_DELAY     5
`define SVR_SRC_HI        4
`define SVR_SRC_LO        2
`define SVR_BIT_DIV16     0
`define SVR_RECOVERY_RST  8'h20
`define SVR_VD_ENABLE     0
`define SVR_VD_LOW        1
`define SVR_VD_HIGH       2
// Interrupt status bits: wake, low-voltage, high-voltage.
`define SVR_IRQ_WIDTH     3
// ----------------------------------------
// Timing
// ----------------------------------------
`define SVR_CLK_PERIOD_NS 10
`define SVR_POR_DELAY_US  1000
`define SVR_POR_DELAY_CYC ((`SVR_POR_DELAY_US * 1000) / `SVR_CLK_PERIOD_NS)
`define SVR_FAST_HOLD_CYC 10
`define SVR_BROWNOUT_CYC  16
`endif

/* core/svr_pkg.sv */
// Types shared by the stop recovery and voltage detect block.
package svr_pkg;
  typedef enum logic [1:0] {
    SVR_SRC_NONE = 2'h0,
    SVR_SRC_PIN  = 2'h1,
    SVR_SRC_NOR  = 2'h2
  } svr_src_kind_t;

  typedef struct packed {
    logic       warm;
    logic       level;
    logic       delay;
    logic [2:0] src;
    logic       rsvd;
    logic       div16;
  } svr_recovery_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [3:0] bank;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } svr_bus_req_t;

  typedef struct packed {
    logic       pinA;
    logic       pinB;
    logic       pinC;
    logic [7:0] port2In;
    logic [7:0] port2Out;
  } svr_wake_pins_t;
endpackage : svr_pkg

/* core/svr_wake_select.sv */
// Wake source selection with level inversion.
`timescale 1ns/100ps
`include "svr_params.svh"
module svr_wake_select
  import svr_pkg::*;
(
  input  wire logic [2:0]     src,
  input  wire logic           level,
  input  wire svr_wake_pins_t pins,
  output logic                wakeHit
);
  logic [7:0] p2Eff;
  logic       raw;

  always_comb begin
    // Output-configured pins read high, which forces any NOR term that includes them low and blocks the wake when the level select is high.
    p2Eff = pins.port2In | pins.port2Out;
    unique case (src)
      3'h2:    raw = pins.pinA;
      3'h3:    raw = pins.pinB;
      3'h4:    raw = pins.pinC;
      3'h5:    raw = pins.port2In[7] | pins.port2Out[7];
      3'h6:    raw = ~|p2Eff[3:0];
      3'h7:    raw = ~|p2Eff;
      default: raw = 1'b0;
    endcase
    // Sources 2 to 7, the NOR terms included, are compared against the level select; sources 0 and 1 never wake.
    if (src == 3'h0 || src == 3'h1) begin
      wakeHit = 1'b0;
    end else begin
      wakeHit = ~(raw ^ level);
    end
  end
endmodule : svr_wake_select

/* core/svr_sync.sv */
// Two-flop synchroniser for an asynchronous level vector.
`timescale 1ns/100ps
module svr_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             core_clk,
  input  wire logic             rstN,
  input  wire logic [WIDTH-1:0] asyncIn,
  output logic      [WIDTH-1:0] syncOut
);
  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] sync_q;

  always_ff @(posedge core_clk or negedge rstN) begin
    if (!rstN) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= asyncIn;
      sync_q <= meta_q;
    end
  end

  assign syncOut = sync_q;
endmodule : svr_sync

/* core/svr_stop_recovery.sv */
// Top of the stop recovery and voltage detect block.
`timescale 1ns/100ps
`include "svr_params.svh"
module svr_stop_recovery
  import svr_pkg::*;
#(
  parameter int POR_DELAY_CYC = `SVR_POR_DELAY_CYC
) (
  input  wire logic           core_clk,
  input  wire logic           reset_n,
  input  wire svr_bus_req_t   busReq,
  output logic [7:0]          busRdata,
  input  wire svr_wake_pins_t wakePins,
  input  wire logic           brownout,
  input  wire logic           lowVoltage,
  input  wire logic           highVoltage,
  output logic                globalReset,
  output logic                clockRun,
  output logic                coreHold,
  output logic                clkDiv16,
  output logic                vdEnable,
  output logic                irq
);
  // ----------------------------------------
  // Reset release and pin synchronisers
  // ----------------------------------------
  logic [1:0] rstSync_q;
  logic       rstN;

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      rstSync_q <= 2'h0;
    end else begin
      rstSync_q <= {rstSync_q[0], 1'b1};
    end
  end
  assign rstN = rstSync_q[1];

  svr_wake_pins_t pinsS;
  logic [2:0]     analogS;

  svr_sync #(.WIDTH(19)) u_pinSync (
    .core_clk (core_clk),
    .rstN     (rstN),
    .asyncIn  (wakePins),
    .syncOut  (pinsS)
  );

  svr_sync #(.WIDTH(3)) u_anaSync (
    .core_clk (core_clk),
    .rstN     (rstN),
    .asyncIn  ({brownout, lowVoltage, highVoltage}),
    .syncOut  (analogS)
  );

  logic boS;
  logic lowS;
  logic highS;
  assign boS   = analogS[2];
  assign lowS  = analogS[1];
  assign highS = analogS[0];

  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  typedef enum logic [4:0] {
    SVR_ST_BROWN = 5'b00001,
    SVR_ST_POR   = 5'b00010,
    SVR_ST_RUN   = 5'b00100,
    SVR_ST_STOP  = 5'b01000,
    SVR_ST_WAKE  = 5'b10000
  } svr_state_t;

  svr_state_t    state_q, state_d;
  logic [31:0]   count_q, count_d;
  svr_recovery_t rec_q, rec_d;
  logic [2:0]    vd_q, vd_d;
  logic [2:0]    irqStat_q, irqStat_d;
  logic [2:0]    irqMask_q, irqMask_d;
  logic [7:0]    rdata_q, rdata_d;
  logic          irq_q, irq_d;
  logic          wakeHit;
  logic          wrRec;
  logic          wrVd;
  logic          wrStat;
  logic          wrMask;
  logic          wrStop;
  logic [2:0]    events;
  logic          lowPrev_q, highPrev_q;
  logic          lowPrev_d, highPrev_d;

  svr_wake_select u_wakeSel (
    .src     (rec_q.src),
    .level   (rec_q.level),
    .pins    (pinsS),
    .wakeHit (wakeHit)
  );

  function automatic logic svrHit(input svr_bus_req_t r, input logic [7:0] a);
    svrHit = (r.addr == a) && (a != `SVR_ADDR_RECOVERY || r.bank == `SVR_BANK_F);
  endfunction : svrHit

  assign wrRec  = busReq.wr && svrHit(busReq, `SVR_ADDR_RECOVERY);
  assign wrVd   = busReq.wr && svrHit(busReq, `SVR_ADDR_VDETECT);
  assign wrStat = busReq.wr && svrHit(busReq, `SVR_ADDR_IRQSTAT);
  assign wrMask = busReq.wr && svrHit(busReq, `SVR_ADDR_IRQMASK);
  assign wrStop = busReq.wr && svrHit(busReq, `SVR_ADDR_STOPCMD) && busReq.wdata[0];

  always_comb begin
    state_d    = state_q;
    count_d    = count_q;
    rec_d      = rec_q;
    vd_d       = vd_q;
    lowPrev_d  = lowPrev_q;
    highPrev_d = highPrev_q;
    events     = 3'h0;
    if (wrRec) begin
      // Bit 7 is never written by software.
      rec_d.level = busReq.wdata[`SVR_BIT_LEVEL];
      rec_d.delay = busReq.wdata[`SVR_BIT_DELAY];
      rec_d.src   = busReq.wdata[`SVR_SRC_HI:`SVR_SRC_LO];
      rec_d.div16 = busReq.wdata[`SVR_BIT_DIV16];
    end
    if (wrVd) begin
      vd_d[`SVR_VD_ENABLE] = busReq.wdata[`SVR_VD_ENABLE];
    end
    // Flags follow the comparator only while enabled and in RUN.
    if (vd_q[`SVR_VD_ENABLE] && state_q == SVR_ST_RUN) begin
      vd_d[`SVR_VD_LOW]  = lowS;
      vd_d[`SVR_VD_HIGH] = highS;
      lowPrev_d          = lowS;
      highPrev_d         = highS;
      events[1]          = lowS & ~lowPrev_q;
      events[2]          = highS & ~highPrev_q;
    end
    unique case (state_q)
      SVR_ST_BROWN: begin
        if (!boS) begin
          state_d = SVR_ST_POR;
          count_d = 32'h0;
        end
      end
      SVR_ST_POR: begin
        count_d = count_q + 32'h1;
        if (count_q >= 32'(POR_DELAY_CYC - 1)) begin
          state_d = SVR_ST_RUN;
        end
      end
      SVR_ST_RUN: begin
        if (wrStop) begin
          state_d = SVR_ST_STOP;
        end
      end
      SVR_ST_STOP: begin
        if (wakeHit) begin
          rec_d.warm = 1'b1;
          events[0]  = 1'b1;
          count_d    = 32'h0;
          state_d    = rec_q.delay ? SVR_ST_WAKE : SVR_ST_RUN;
        end
      end
      SVR_ST_WAKE: begin
        count_d = count_q + 32'h1;
        if (count_q >= 32'(POR_DELAY_CYC - 1)) begin
          state_d = SVR_ST_RUN;
        end
      end
    endcase
    if (boS) begin
      // Brownout restarts the sequencer and the recovery and detect registers as a cold start.
      state_d = SVR_ST_BROWN;
      rec_d   = `SVR_RECOVERY_RST;
      vd_d    = 3'h0;
    end
  end

  // ----------------------------------------
  // Interrupts and read data
  // ----------------------------------------
  always_comb begin
    irqStat_d = irqStat_q;
    irqMask_d = irqMask_q;
    if (wrStat) begin
      irqStat_d = irqStat_q & ~busReq.wdata[2:0];
    end
    // A new event wins over a clear in the same cycle.
    irqStat_d = irqStat_d | events;
    if (wrMask) begin
      irqMask_d = busReq.wdata[2:0];
    end
    irq_d   = |(irqStat_d & irqMask_d);
    rdata_d = 8'h0;
    if (busReq.rd) begin
      if (svrHit(busReq, `SVR_ADDR_RECOVERY)) begin
        rdata_d = {rec_q.warm, 7'h0};
      end else if (svrHit(busReq, `SVR_ADDR_VDETECT)) begin
        rdata_d = {5'h0, vd_q};
      end else if (svrHit(busReq, `SVR_ADDR_IRQSTAT)) begin
        rdata_d = {5'h0, irqStat_q};
      end else if (svrHit(busReq, `SVR_ADDR_IRQMASK)) begin
        rdata_d = {5'h0, irqMask_q};
      end
    end
  end

  always_ff @(posedge core_clk or negedge rstN) begin
    if (!rstN) begin
      state_q    <= SVR_ST_POR;
      count_q    <= 32'h0;
      rec_q      <= `SVR_RECOVERY_RST;
      vd_q       <= 3'h0;
      lowPrev_q  <= 1'b0;
      highPrev_q <= 1'b0;
      irqStat_q  <= 3'h0;
      irqMask_q  <= 3'h0;
      irq_q      <= 1'b0;
      rdata_q    <= 8'h0;
    end else begin
      state_q    <= state_d;
      count_q    <= count_d;
      rec_q      <= rec_d;
      vd_q       <= vd_d;
      lowPrev_q  <= lowPrev_d;
      highPrev_q <= highPrev_d;
      irqStat_q  <= irqStat_d;
      irqMask_q  <= irqMask_d;
      irq_q      <= irq_d;
      rdata_q    <= rdata_d;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  logic gr_q, run_q, hold_q, div_q, ven_q;

  always_ff @(posedge core_clk or negedge rstN) begin
    if (!rstN) begin
      gr_q   <= 1'b1;
      run_q  <= 1'b1;
      hold_q <= 1'b1;
      div_q  <= 1'b0;
      ven_q  <= 1'b0;
    end else begin
      gr_q   <= (state_d == SVR_ST_BROWN);
      run_q  <= (state_d != SVR_ST_STOP);
      hold_q <= (state_d != SVR_ST_RUN);
      div_q  <= rec_d.div16;
      ven_q  <= vd_d[`SVR_VD_ENABLE] && (state_d != SVR_ST_STOP);
    end
  end

  assign busRdata    = rdata_q;
  assign globalReset = gr_q;
  assign clockRun    = run_q;
  assign coreHold    = hold_q;
  assign clkDiv16    = div_q;
  assign vdEnable    = ven_q;
  assign irq         = irq_q;
endmodule : svr_stop_recovery

/* testbench/svr_chk.sv */
// Port checker for the stop recovery and voltage detect block.
`timescale 1ns/100ps
module svr_chk
  import svr_pkg::*;
#(
  parameter int POR_DELAY_CYC = 8
) (
  input wire logic           core_clk,
  input wire logic           reset_n,
  input wire svr_bus_req_t   busReq,
  input wire logic [7:0]     busRdata,
  input wire svr_wake_pins_t wakePins,
  input wire logic           brownout,
  input wire logic           lowVoltage,
  input wire logic           highVoltage,
  input wire logic           globalReset,
  input wire logic           clockRun,
  input wire logic           coreHold,
  input wire logic           clkDiv16,
  input wire logic           vdEnable,
  input wire logic           irq
);
  int   relCnt_q;
  int   relCnt_d;
  logic recSel;
  assign recSel = busReq.bank == 4'hf && busReq.addr == 8'h0b;
  // Counts from release, so the core must be held for at least the delay.
  always_comb relCnt_d = (relCnt_q < POR_DELAY_CYC) ? relCnt_q + 1 : relCnt_q;
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) relCnt_q <= 0;
    else relCnt_q <= relCnt_d;
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  AST_RDIDLE: assert property (busRdata != 8'h00 |-> $past(busReq.rd))
    else $error("read data outside read slot");
  AST_RECRD: assert property (busReq.rd && recSel |=> busRdata[6:0] == 7'h00)
    else $error("recovery write-only bits visible");
  AST_VDRD: assert property (busReq.rd && busReq.addr == 8'h0c |=> busRdata[7:3] == 5'h00)
    else $error("voltage register reserved bits set");
  AST_DIV: assert property (busReq.wr && recSel |-> ##2 clkDiv16 == $past(busReq.wdata[0], 2))
    else $error("divider select not taken");
  AST_VDEN: assert property (busReq.wr && busReq.addr == 8'h0c ##1 clockRun [*2]
    |-> vdEnable == $past(busReq.wdata[0], 2)) else $error("detect enable not taken");
  AST_STOPVD: assert property (!clockRun [*2] |-> !vdEnable)
    else $error("detection active in stop");
  AST_HOLD: assert property (!clockRun || globalReset || relCnt_q < POR_DELAY_CYC |-> coreHold)
    else $error("core released early");
  AST_BROWN: assert property (brownout [*5] |-> globalReset)
    else $error("no global reset on brownout");
  AST_STOPCMD: assert property (busReq.wr && busReq.addr == 8'h0f && busReq.wdata[0] && !coreHold
    |-> ##[1:2] !clockRun) else $error("stop not entered");
endmodule : svr_chk

/* testbench/svr_far_side.sv */
// Model of the wake pins and supply comparator.
`timescale 1ns/100ps
module svr_far_side
  import svr_pkg::*;
(
  input  wire logic           core_clk,
  input  wire svr_wake_pins_t pinReq,
  input  wire logic [2:0]     supplyReq,
  output svr_wake_pins_t      wakePins,
  output logic [2:0]          supply
);
  int holdCnt_q;
  initial begin
    wakePins = 19'h00f00;
    supply = 3'h0;
    holdCnt_q = 0;
  end
  // Each pin level stands eleven clocks, so a fast wake is always recognised.
  always @(posedge core_clk) begin
    supply <= supplyReq;
    if (holdCnt_q > 0) holdCnt_q <= holdCnt_q - 1;
    else if (pinReq !== wakePins) begin
      wakePins <= pinReq;
      holdCnt_q <= 10;
    end
  end
endmodule : svr_far_side

/* testbench/testbench.sv */
// Self-checking bench for the stop recovery block.
`timescale 1ns/100ps
module testbench;
  import svr_pkg::*;
  logic           core_clk;
  logic           reset_n;
  svr_bus_req_t   busReq;
  logic [7:0]     busRdata;
  svr_wake_pins_t wakePins;
  svr_wake_pins_t pinReq;
  logic [2:0]     supply;
  logic [2:0]     supplyReq;
  logic           globalReset;
  logic           clockRun;
  logic           coreHold;
  logic           clkDiv16;
  logic           vdEnable;
  logic           irq;
  logic [7:0]     rdat;
  int             num_errors;
  int             num_checks;
  int             cyc;
  // Row i is source i: {wake expected, pinA..C, port 2 input}.
  logic [11:0]    rows [8] = '{12'h780, 12'h780, 12'hc0f, 12'ha0f, 12'h90f, 12'h88f, 12'h8f0, 12'h800};

  svr_stop_recovery #(.POR_DELAY_CYC(8)) i_dut (.core_clk(core_clk), .reset_n(reset_n), .busReq(busReq),
    .busRdata(busRdata), .wakePins(wakePins), .brownout(supply[2]), .lowVoltage(supply[1]),
    .highVoltage(supply[0]), .globalReset(globalReset), .clockRun(clockRun), .coreHold(coreHold),
    .clkDiv16(clkDiv16), .vdEnable(vdEnable), .irq(irq));
  svr_far_side i_far (.core_clk(core_clk), .pinReq(pinReq), .supplyReq(supplyReq), .wakePins(wakePins),
    .supply(supply));

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : report_and_stop
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    num_checks++;
    if (g !== e) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic bchk(input string n, input logic e, input logic g);
    chk(n, {7'h0, e}, {7'h0, g});
  endtask : bchk
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
  endtask : tick
  // Strobe for one cycle; read data is taken at the edge after the one that ends its slot.
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
    busReq <= '{addr: a, bank: 4'hf, wdata: d, wr: w, rd: !w};
    @(posedge core_clk);
    busReq.wr <= 1'b0;
    busReq.rd <= 1'b0;
    @(posedge core_clk);
    rdat = busRdata;
  endtask : bus
  task automatic rd_chk(input string n, input logic [7:0] a, input logic [7:0] e);
    bus(1'b0, a, 8'h00);
    chk(n, e, rdat);
  endtask : rd_chk
  task automatic wait_lvl(input logic run, input logic v);
    for (int k = 0; k < 40 && (run ? clockRun : coreHold) !== v; k++) @(posedge core_clk);
  endtask : wait_lvl
  task automatic do_reset;
    reset_n <= 1'b0;
    tick(6);
    reset_n <= 1'b1;
    wait_lvl(1'b0, 1'b0);
    tick(1);
  endtask : do_reset

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 6000) begin
      num_errors++;
      report_and_stop();
    end
  end

  initial begin
    reset_n = 1'b0;
    busReq = '0;
    pinReq = 19'h00f00;
    supplyReq = 3'h0;
    num_errors = 0;
    num_checks = 0;
    cyc = 0;
    @(posedge core_clk);
    do_reset();
    // The bench clock is not a crystal, so the fast wake rows may drop the delay.
    for (int i = 0; i < 8; i++) begin
      bus(1'b1, 8'h0b, {3'b010, i[2:0], 2'b00});
      bus(1'b1, 8'h0f, 8'h01);
      tick(3);
      bchk("stopped", 1'b0, clockRun);
      pinReq <= {rows[i][10:0], 8'h00};
      for (int k = 0; k < 30 && clockRun !== 1'b1; k++) @(posedge core_clk);
      bchk("woken", rows[i][11], clockRun);
      if (rows[i][11]) begin
        tick(2);
        bchk("fastHold", 1'b0, coreHold);
        rd_chk("warm", 8'h0b, 8'h80);
      end else do_reset();
      pinReq <= 19'h00f00;
      tick(12);
      $display("wake row %0d done", i);
    end
    bchk("irqMasked", 1'b0, irq);
    bus(1'b1, 8'h0e, 8'h01);
    tick(1);
    bchk("irqSet", 1'b1, irq);
    rd_chk("status", 8'h0d, 8'h01);
    bus(1'b1, 8'h0d, 8'h01);
    tick(1);
    bchk("irqClear", 1'b0, irq);
    $display("interrupt test done");
    bus(1'b1, 8'h0b, 8'h78);
    pinReq <= 19'h00001;
    tick(12);
    bus(1'b1, 8'h0f, 8'h01);
    tick(20);
    bchk("forcedPin", 1'b0, clockRun);
    pinReq <= 19'h00000;
    wait_lvl(1'b1, 1'b1);
    tick(3);
    bchk("delayHold", 1'b1, coreHold);
    wait_lvl(1'b0, 1'b0);
    bchk("delayEnd", 1'b0, coreHold);
    $display("port 2 delay test done");
    bus(1'b1, 8'h0b, 8'hff);
    tick(1);
    bchk("div16", 1'b1, clkDiv16);
    rd_chk("recRead", 8'h0b, 8'h80);
    bus(1'b1, 8'h0b, 8'h20);
    bus(1'b1, 8'h0c, 8'hff);
    tick(1);
    bchk("vdEnable", 1'b1, vdEnable);
    supplyReq <= 3'b010;
    tick(6);
    rd_chk("vdFlags", 8'h0c, 8'h03);
    bus(1'b1, 8'h0f, 8'h01);
    tick(2);
    bchk("vdStop", 1'b0, vdEnable);
    supplyReq <= 3'b100;
    tick(8);
    bchk("globalReset", 1'b1, globalReset);
    supplyReq <= 3'b000;
    wait_lvl(1'b0, 1'b0);
    rd_chk("afterBrown", 8'h0b, 8'h00);
    rd_chk("unmapped", 8'h10, 8'h00);
    pinReq <= 19'h40000;
    bus(1'b1, 8'h0b, 8'h08);
    tick(12);
    bus(1'b1, 8'h0f, 8'h01);
    tick(3);
    bchk("lowStopped", 1'b0, clockRun);
    pinReq <= 19'h00000;
    wait_lvl(1'b1, 1'b1);
    bchk("lowWake", 1'b1, clockRun);
    $display("supply test done");
    report_and_stop();
  end
endmodule : testbench

bind svr_stop_recovery svr_chk #(.POR_DELAY_CYC(POR_DELAY_CYC)) i_chk (.core_clk(core_clk), .reset_n(reset_n),
  .busReq(busReq), .busRdata(busRdata), .wakePins(wakePins), .brownout(brownout), .lowVoltage(lowVoltage),
  .highVoltage(highVoltage), .globalReset(globalReset), .clockRun(clockRun), .coreHold(coreHold),
  .clkDiv16(clkDiv16), .vdEnable(vdEnable), .irq(irq));
